// ### core/icmc_pkg.sv
// Package of constants and carrier types for the input connector mode control.
// How it works
// - Second halt-control input asserted stops the machine; left open with the first it runs.
// - Octal load trigger starts octal input only while in manual halt.
// - Program sample copies six upper discrete inputs into accumulator bits 25-30.
// - Each upper discrete input is echoed on a buffered output.
// - Five lower inputs sampled likewise; open or active means asserted.
// - A short strobe on the stretcher input yields one 6 us output pulse.
// - Fill and verify indicator drives follow fill and verify modes.
// - In halt, code select picks teleprinter or FIELDATA octal reading.
// - In run, asserted code select skips all input parity checking.
// - Reader code select open gives teleprinter, grounded gives FIELDATA even.
// - Parity sense and code select never affect the mechanical reader.
// - Working region selectable as 4, 12 or 16 channels at 70, 50 or 40-76.
// - Permanent region writes blocked unless write-enable lines are energized.
// - Parity sense open checks odd parity, grounded checks even parity.
// - First halt-control input asserted halts, open runs, with the second.
package icmc_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned STRETCH_NS = 6000;
    localparam int unsigned STRETCH_CYC = STRETCH_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned UPPER_LSB = 25;
    localparam int unsigned UPPER_N = 6;
    localparam int unsigned LOWER_LSB = 14;
    localparam int unsigned LOWER_N = 5;
    localparam int unsigned ACC_W = 32;
    localparam logic [5:0] WORK4_BASE = 6'o70;
    localparam logic [5:0] WORK12_BASE = 6'o50;
    localparam logic [5:0] WORK16_BASE = 6'o40;
    localparam logic [5:0] WORK_TOP = 6'o76;
    localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ICMC_WS_4 = 2'b00,
        ICMC_WS_12 = 2'b01,
        ICMC_WS_16 = 2'b10
    } icmc_wsize_t;

    typedef enum logic [1:0] {
        ICMC_CODE_TTY = 2'b00,
        ICMC_CODE_FD = 2'b01,
        ICMC_CODE_FD_EVEN = 2'b10
    } icmc_code_t;

    typedef struct packed {
        logic halt;
        logic octal_start;
        icmc_code_t octal_code;
        logic parity_skip;
        logic parity_even;
        icmc_code_t reader_code;
    } icmc_mode_t;
endpackage : icmc_pkg

// ### core/icmc_stretch.sv
// Non-retriggerable pulse stretcher for short character strobes.
module icmc_stretch #(
    parameter int unsigned CYCLES = 300
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronized trigger and pulse
    input wire logic trig,
    output logic pulse
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic trig_q;
    logic pulse_q;
    logic pulse_d;

    if (CYCLES < 1)
    begin : g_len_check
        $error("Stretcher length must be at least one cycle.");
    end

    always_comb
    begin
        cnt_d = cnt_q;
        pulse_d = pulse_q;
        if (pulse_q)
        begin
            // A trigger during the pulse is ignored, not restarted.
            if (cnt_q == CW'(1))
                pulse_d = 1'b0;
            cnt_d = cnt_q - CW'(1);
        end
        else if (trig && !trig_q)
        begin
            pulse_d = 1'b1;
            cnt_d = CW'(CYCLES);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
            trig_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
            trig_q <= trig;
        end
    end

    assign pulse = pulse_q;
endmodule : icmc_stretch

// ### core/icmc_top.sv
// Mode, discrete input and write protection logic of the input connector.
module icmc_top
#(
    parameter int unsigned STRETCH_LEN = icmc_pkg::STRETCH_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Halt control and octal load, 1 means asserted
    input wire logic halt_control_a,
    input wire logic halt_control_b,
    input wire logic octal_load_trigger,
    // Operating mode from the sequencer
    input wire logic fill_mode,
    input wire logic verify_mode,
    // Discrete inputs, 1 means active or open, 0 means grounded
    input wire logic [icmc_pkg::UPPER_N-1:0] upper_discrete_in,
    input wire logic [icmc_pkg::LOWER_N-1:0] lower_discrete_in,
    input wire logic sample_discrete,
    output logic [icmc_pkg::ACC_W-1:0] accumulator,
    output logic [icmc_pkg::UPPER_N-1:0] upper_discrete_echo,
    // Pulse stretcher
    input wire logic stretcher_trigger_in,
    output logic stretcher_pulse_out,
    // Indicator drives
    output logic fill_indicator_drive,
    output logic verify_indicator_drive,
    // Code and parity selects, 1 means open or true
    input wire logic code_select_parity_skip,
    input wire logic reader_code_select,
    input wire logic parity_sense_select,
    output icmc_pkg::icmc_mode_t mode,
    // Memory write protection
    input wire logic [1:0] work_size_sel,
    input wire logic cold_write_enable,
    input wire logic write_req,
    input wire logic [5:0] write_channel,
    output logic write_allow
);
    import icmc_pkg::*;
    localparam int unsigned NS = 4 + UPPER_N + LOWER_N + 2 + 3;

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    logic hca_s;
    logic hcb_s;
    logic olt_s;
    logic stt_s;
    logic [UPPER_N-1:0] up_s;
    logic [LOWER_N-1:0] lo_s;
    logic cwe_s;
    logic [1:0] ws_s;
    logic cps_s;
    logic rcs_s;
    logic pss_s;
    logic olt_q;
    logic olt_d;
    logic pulse;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [UPPER_N-1:0] echo_q;
    logic [UPPER_N-1:0] echo_d;
    icmc_mode_t mode_q;
    icmc_mode_t mode_d;
    logic fill_q;
    logic fill_d;
    logic ver_q;
    logic ver_d;
    logic wa_q;
    logic wa_d;
    logic [5:0] base;

    // Field positions are fixed, so a wider field would spill past bit 31.
    if (UPPER_N + UPPER_LSB > ACC_W)
    begin : g_upper_fit
        $error("Upper discrete field does not fit the accumulator.");
    end
    if (LOWER_N + LOWER_LSB > UPPER_LSB)
    begin : g_lower_fit
        $error("Lower discrete field runs into the upper field.");
    end
    if (STRETCH_LEN < 1)
    begin : g_stretch_len
        $error("Stretcher length must be at least one cycle.");
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Every halt, trigger, discrete, size and select pin passes two stages; only the second stage is read.
    assign raw = {halt_control_a, halt_control_b, octal_load_trigger,
                  stretcher_trigger_in, upper_discrete_in, lower_discrete_in,
                  work_size_sel, code_select_parity_skip, reader_code_select,
                  parity_sense_select};
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    assign {hca_s, hcb_s, olt_s, stt_s, up_s, lo_s, ws_s, cps_s, rcs_s,
            pss_s} = s2_q;

    // Write enable lines are a level from the same supply, still synchronized.
    logic [1:0] cwe_sync_q;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cwe_sync_q <= 2'h0;
        else
            cwe_sync_q <= {cwe_sync_q[0], cold_write_enable};
    end
    assign cwe_s = cwe_sync_q[1];

    icmc_stretch #(
        .CYCLES(STRETCH_LEN)
    ) u_stretch (
        .clk(sys_clk),
        .rst_n(rst_n),
        .trig(stt_s),
        .pulse(pulse)
    );

    always_comb
    begin
        acc_d = acc_q;
        if (sample_discrete)
        begin
            acc_d[UPPER_LSB +: UPPER_N] = up_s;
            acc_d[LOWER_LSB +: LOWER_N] = lo_s;
        end
    end

    always_comb
    begin
        mode_d.halt = hca_s || hcb_s;
        // Octal start fires once per rising trigger, and only from halt.
        mode_d.octal_start = mode_q.halt && olt_s && !olt_q;
        mode_d.octal_code = cps_s ? ICMC_CODE_TTY : ICMC_CODE_FD;
        // Registered halt is used, so the skip trails a mode change a cycle.
        mode_d.parity_skip = !mode_q.halt && cps_s;
        mode_d.parity_even = !pss_s;
        // The reader looks at its own select only.
        mode_d.reader_code = rcs_s ? ICMC_CODE_TTY
                                   : ICMC_CODE_FD_EVEN;
        fill_d = fill_mode;
        ver_d = verify_mode;
        echo_d = up_s;
        olt_d = olt_s;
    end

    always_comb
    begin
        if (ws_s == ICMC_WS_16)
            base = WORK16_BASE;
        else if (ws_s == ICMC_WS_12)
            base = WORK12_BASE;
        else
            base = WORK4_BASE;
        // Channels above the working top are always permanent.
        wa_d = write_req && (cwe_s ||
               (write_channel >= base &&
                write_channel <= WORK_TOP));
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_q <= ACC_RESET;
        else
            acc_q <= acc_d;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            echo_q <= '0;
            mode_q <= '0;
            fill_q <= 1'b0;
            ver_q <= 1'b0;
            olt_q <= 1'b0;
        end
        else
        begin
            echo_q <= echo_d;
            mode_q <= mode_d;
            fill_q <= fill_d;
            ver_q <= ver_d;
            olt_q <= olt_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            wa_q <= 1'b0;
        else
            wa_q <= wa_d;
    end

    assign accumulator = acc_q;
    assign upper_discrete_echo = echo_q;
    assign stretcher_pulse_out = pulse;
    assign fill_indicator_drive = fill_q;
    assign verify_indicator_drive = ver_q;
    assign mode = mode_q;
    assign write_allow = wa_q;
endmodule : icmc_top

// ### sim/icmc_top_properties.sv
// Concurrent checks on the ports of the input connector mode control.
module icmc_props
#(
    parameter int unsigned STRETCH_LEN = 300
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Watched inputs
    input wire logic halt_control_a,
    input wire logic halt_control_b,
    input wire logic [icmc_pkg::UPPER_N-1:0] upper_discrete_in,
    input wire logic [icmc_pkg::LOWER_N-1:0] lower_discrete_in,
    input wire logic sample_discrete,
    input wire logic fill_mode,
    input wire logic parity_sense_select,
    input wire logic cold_write_enable,
    input wire logic write_req,
    input wire logic [5:0] write_channel,
    // Watched outputs
    input wire logic [icmc_pkg::ACC_W-1:0] accumulator,
    input wire logic [icmc_pkg::UPPER_N-1:0] upper_discrete_echo,
    input wire logic stretcher_pulse_out,
    input wire logic fill_indicator_drive,
    input wire icmc_pkg::icmc_mode_t mode,
    input wire logic write_allow
);
    timeunit 1ns;
    timeprecision 1ns;
    import icmc_pkg::*;
    logic [3:0] up_q;
    logic [8:0] run_q;
    wire live = up_q == 4'hf;
    // Early cycles are skipped while the sync chains still hold reset.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            up_q <= 4'h0;
            run_q <= 9'h000;
        end
        else
        begin
            up_q <= live ? up_q : up_q + 4'h1;
            run_q <= stretcher_pulse_out ? run_q + 9'h001 : 9'h000;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence cold_off_s; !cold_write_enable [*4]; endsequence
    sequence top_req_s; write_req && write_channel == 6'h3f; endsequence
    halt_follow_a:
        assert property (live |-> mode.halt ==
            $past(halt_control_a | halt_control_b, 3)) else $error("halt");
    echo_follow_a:
        assert property (live |-> upper_discrete_echo ==
            $past(upper_discrete_in, 3)) else $error("echo");
    acc_load_a:
        assert property (live && sample_discrete |=> accumulator == {1'b0,
            $past(upper_discrete_in, 3), 6'h00, $past(lower_discrete_in, 3),
            14'h0000}) else $error("accumulator");
    parity_even_a:
        assert property (live |-> mode.parity_even ==
            !$past(parity_sense_select, 3)) else $error("parity sense");
    fill_drive_a:
        assert property (live |-> fill_indicator_drive == $past(fill_mode))
        else $error("fill drive");
    octal_gate_a:
        assert property (live && mode.octal_start |-> $past(mode.halt))
        else $error("octal start");
    cold_block_a:
        assert property (cold_off_s ##0 top_req_s |=> !write_allow)
        else $error("cold write");
    stretch_len_a:
        assert property ($fell(stretcher_pulse_out) |-> run_q == STRETCH_LEN)
        else $error("stretch length");
endmodule : icmc_props

bind icmc_top icmc_props #(.STRETCH_LEN(STRETCH_LEN)) props_u (.sys_clk,
    .arst_n, .halt_control_a, .halt_control_b, .upper_discrete_in,
    .lower_discrete_in, .sample_discrete, .fill_mode, .parity_sense_select,
    .cold_write_enable, .write_req, .write_channel, .accumulator,
    .upper_discrete_echo, .stretcher_pulse_out, .fill_indicator_drive, .mode,
    .write_allow);

// ### sim/icmc_strobe_src.sv
// Peripheral strobe source giving one short character strobe per request.
module icmc_strobe_src #(
    parameter int unsigned WIDTH = 75
) (
    // Clock and request
    input wire logic clk,
    input wire logic go,
    // Strobe toward the stretcher input
    output logic strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned left = 0;
    assign strobe = left != 0;
    // A 1.5 us strobe, so the stretched pulse outlasts it.
    always @(posedge clk)
        left <= go ? WIDTH : (left != 0 ? left - 1 : 0);
endmodule : icmc_strobe_src

// ### sim/icmc_top_tb.sv
// Self-checking bench of the input connector mode control.
module icmc_top_tb;
    import icmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0, arst_n = 1'h0, ha = 1'h0, hb = 1'h0, olt = 1'h0;
    logic fm = 1'h0, vm = 1'h0, smp = 1'h0, cs = 1'h0, rs = 1'h0, ps = 1'h0;
    logic cold = 1'h0, wreq = 1'h0, go = 1'h0, seen, strb, sp, fid, vid, wal;
    logic [5:0] up = 6'h00, wch = 6'h00, echo;
    logic [4:0] lo = 5'h00;
    logic [1:0] wsz = 2'h0;
    logic [31:0] acc, lf = 32'h1ed9;
    icmc_mode_t md;
    int errors = 0, num_checks = 0, n;
    always #10 sys_clk = ~sys_clk;
    icmc_strobe_src src_u (.clk(sys_clk), .go(go), .strobe(strb));
    icmc_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .halt_control_a(ha),
        .halt_control_b(hb), .octal_load_trigger(olt), .fill_mode(fm),
        .verify_mode(vm), .upper_discrete_in(up), .lower_discrete_in(lo),
        .sample_discrete(smp), .accumulator(acc), .upper_discrete_echo(echo),
        .stretcher_trigger_in(strb), .stretcher_pulse_out(sp),
        .fill_indicator_drive(fid), .verify_indicator_drive(vid),
        .code_select_parity_skip(cs), .reader_code_select(rs),
        .parity_sense_select(ps), .mode(md), .work_size_sel(wsz),
        .cold_write_enable(cold), .write_req(wreq), .write_channel(wch),
        .write_allow(wal));
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic tick(int k);
        repeat (k) @(posedge sys_clk);
    endtask : tick
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    function automatic logic exp_wr(logic [1:0] z, logic [5:0] c, logic w);
        logic [5:0] b;
        b = z == 2'h1 ? WORK12_BASE : z == 2'h2 ? WORK16_BASE : WORK4_BASE;
        return w || (c >= b && c <= WORK_TOP);
    endfunction : exp_wr
    initial
    begin
        tick(10);
        arst_n <= 1'h1;
        tick(4);
        // The first two rounds drive all ones and all zeros.
        for (int i = 0; i < 18; i++)
        begin
            lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
            {ha, hb, cs, rs, ps, fm, vm, up, lo} <= i == 0 ? 18'h3ffff :
                i == 1 ? 18'h0 : lf[17:0];
            tick(6);
            smp <= 1'h1;
            tick(1);
            smp <= 1'h0;
            tick(1);
            #1;
            chk("acc", acc, {1'h0, up, 6'h0, lo, 14'h0});
            chk("echo", echo, up);
            chk("halt", md.halt, ha | hb);
            chk("drives", {fid, vid}, {fm, vm});
            chk("even", md.parity_even, !ps);
            chk("reader", md.reader_code,
                rs ? ICMC_CODE_TTY : ICMC_CODE_FD_EVEN);
            if (ha | hb)
                chk("octal code", md.octal_code,
                    cs ? ICMC_CODE_TTY : ICMC_CODE_FD);
            else
                chk("skip", md.parity_skip, cs);
            tick(1);
        end
        $display("mode test done");
        for (int h = 0; h < 2; h++)
        begin
            {ha, hb} <= {h[0], 1'h0};
            tick(6);
            olt <= 1'h1;
            seen = 1'h0;
            repeat (8)
            begin
                tick(1);
                #1;
                seen |= md.octal_start;
            end
            tick(1);
            olt <= 1'h0;
            chk("octal start", seen, h[0]);
        end
        $display("octal test done");
        for (int s = 0; s < 5; s++)
        begin
            {wsz, cold} <= {s[1:0], s == 4};
            tick(4);
            for (int c = 0; c < 64; c++)
            begin
                tick(1);
                {wreq, wch} <= {1'h1, c[5:0]};
                tick(1);
                wreq <= 1'h0;
                #1;
                chk("write", wal, exp_wr(wsz, wch, cold));
            end
        end
        $display("write test done");
        n = 0;
        for (int k = 0; k < 400; k++)
        begin
            tick(1);
            go <= k == 0 || k == 100;
            #1;
            n += sp;
        end
        chk("stretch", n, STRETCH_CYC);
        $display("stretch test done");
        stop_test();
    end
endmodule : icmc_top_tb
